// file: rtl/tariff_period_accumulator.sv
// calendar-driven tariff period energy accumulator with wishbone register access
//
// Functional notes
// - storage for up to twenty yearly calendars
// - one of sixteen schedules per day
// - schedule splits day into fifteen-minute slots
// - slot picks one of eight rate registers
// - four seasonal and separate monthly totals
// - start date ends preceding period; spans years
// - season closes at midnight before start
// - month closes at midnight of billing day
// - year end stops unless next calendar exists
// - without next calendar, last accumulation ends 12/31
// - period end copies current to prior, clears
// - prior and current totals always readable
// - calendar writes never pause accumulation
// - replacement takes effect at period end
// - reset command clears only current totals
// - only reset_n clears stored prior totals
// - year crossing switches to next calendar
// - summer time automatic or host-dated mode
// - block or rolling demand, programmable interval
`timescale 1ns/1ps
`include "tariff_cfg.svh"

module tariff_period_accumulator #(
   parameter int NUM_CAL = `CAL_NUM,
   parameter int ACC_W = 32,
   parameter int ENERGY_W = 16
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [15:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire tariff_pkg::tod_t tod_i,
   input wire logic energy_valid_i,
   input wire logic [ENERGY_W-1:0] energy_amount_i,
   output logic running_o,
   output logic automatic_summer_time_o
);

   localparam int CW = $clog2(NUM_CAL);

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   function automatic int day_addr(input logic [CW-1:0] cal, input logic [8:0] doy);
      return int'(cal) * `DAY_NUM + int'(doy) - 1;
   endfunction

   function automatic int slot_addr(input logic [CW-1:0] cal, input logic [3:0] sch,
                                    input logic [6:0] slot);
      return (int'(cal) * `SCHED_NUM + int'(sch)) * `SLOT_NUM + int'(slot);
   endfunction

   // byte-lane merge so narrow fields honour wb_sel_i
   function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] nw,
                                            input logic [3:0] sel);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) begin
            r[b*8 +: 8] = nw[b*8 +: 8];
         end
      end
      return r;
   endfunction

   // ---------------------------------------------------------------
   // storage
   // ---------------------------------------------------------------
   // calendar storage
   logic [3:0] day_mem [NUM_CAL*`DAY_NUM];
   logic [2:0] slot_mem [NUM_CAL*`SCHED_NUM*`SLOT_NUM];

   logic [6:0] year_q [NUM_CAL];
   logic [6:0] year_d [NUM_CAL];
   logic valid_q [NUM_CAL];
   logic valid_d [NUM_CAL];
   logic [8:0] season_q [NUM_CAL][`SEASON_NUM];
   logic [8:0] season_d [NUM_CAL][`SEASON_NUM];
   logic [4:0] bill_q [NUM_CAL][`MONTH_NUM];
   logic [4:0] bill_d [NUM_CAL][`MONTH_NUM];
   logic [ACC_W-1:0] acc_q [`GROUP_NUM][`RATE_NUM];
   logic [ACC_W-1:0] acc_d [`GROUP_NUM][`RATE_NUM];
   logic [ACC_W-1:0] sub_q [`ROLL_SUBS];
   logic [ACC_W-1:0] sub_d [`ROLL_SUBS];

   logic ack_q, ack_d;
   logic [31:0] dat_q, dat_d;
   logic [CW-1:0] sel_q, sel_d;
   logic [CW-1:0] act_q, act_d;
   logic run_q, run_d;
   logic dst_en_q, dst_en_d;
   tariff_pkg::dst_mode_t dst_mode_q, dst_mode_d;
   tariff_pkg::demand_type_t dem_type_q, dem_type_d;
   logic [8:0] dst_start_q, dst_start_d;
   logic [8:0] dst_end_q, dst_end_d;
   logic dst_q, dst_d;
   logic [7:0] dem_int_q, dem_int_d;
   logic [7:0] dem_cnt_q, dem_cnt_d;
   logic [ACC_W-1:0] dem_acc_q, dem_acc_d;
   logic [ACC_W-1:0] demand_q, demand_d;
   logic [6:0] slot_q, slot_d;
   logic seen_q, seen_d;
   tariff_pkg::tod_t prev_q, prev_d;

   // ---------------------------------------------------------------
   // bus decode
   // ---------------------------------------------------------------
   logic req, wr;
   logic day_hit, slot_hit;
   int day_idx, slot_idx;

   always_comb begin
      req = wb_cyc_i && wb_stb_i;
      // write lands on the edge at which the master sees ack
      wr = req && wb_we_i && ack_q;
      day_idx = int'(wb_adr_i[10:2]);
      slot_idx = int'(wb_adr_i[12:2]);
      day_hit = (wb_adr_i[15:12] == `REGION_DAY) && (day_idx < `DAY_NUM);
      slot_hit = (wb_adr_i[15:13] == `REGION_SLOT) && (slot_idx < `SCHED_NUM * `SLOT_NUM);
   end

   // ---------------------------------------------------------------
   // calendar lookup for the present year
   // ---------------------------------------------------------------
   logic cal_hit;
   logic [CW-1:0] cal_idx;

   // highest slot tagged with the year wins, so replacements go to a higher slot
   always_comb begin
      cal_hit = 1'b0;
      cal_idx = '0;
      for (int c = 0; c < NUM_CAL; c++) begin
         if (valid_q[c] && (year_q[c] == tod_i.year)) begin
            cal_hit = 1'b1;
            cal_idx = CW'(c);
         end
      end
   end

   // ---------------------------------------------------------------
   // slot and rate selection
   // ---------------------------------------------------------------
   logic [10:0] min_eff;
   logic [3:0] sched_sel;
   logic [2:0] rate_sel;

   always_comb begin
      // shifted minute of day over fifteen
      min_eff = tod_i.minute + (dst_q ? `DST_SHIFT_MIN : 11'h000);
      if (min_eff >= `DAY_MIN) begin
         min_eff = min_eff - `DAY_MIN;
      end
      slot_d = 7'(min_eff / `SLOT_MIN);
      sched_sel = day_mem[day_addr(act_q, tod_i.doy)];
      rate_sel = slot_mem[slot_addr(act_q, sched_sel, slot_q)];
   end

   // ---------------------------------------------------------------
   // main next-state logic
   // ---------------------------------------------------------------
   logic new_day, new_year, new_min, reset_cmd, accept;
   logic season_end, month_end, close_any;
   logic [CW-1:0] act_chk;
   logic [ACC_W-1:0] sub_sum;
   logic [31:0] rd;
   logic [4:0] sun_ofs;

   always_comb begin
      year_d = year_q;
      valid_d = valid_q;
      season_d = season_q;
      bill_d = bill_q;
      acc_d = acc_q;
      sub_d = sub_q;
      sel_d = sel_q;
      act_d = act_q;
      run_d = run_q;
      dst_en_d = dst_en_q;
      dst_mode_d = dst_mode_q;
      dem_type_d = dem_type_q;
      dst_start_d = dst_start_q;
      dst_end_d = dst_end_q;
      dem_int_d = dem_int_q;
      dem_cnt_d = dem_cnt_q;
      dem_acc_d = dem_acc_q;
      demand_d = demand_q;
      seen_d = 1'b1;
      prev_d = tod_i;
      reset_cmd = 1'b0;
      sub_sum = '0;

      // register writes
      if (wr) begin
         unique case (wb_adr_i)
            `OFF_CTRL: begin
               if (wb_sel_i[0]) begin
                  reset_cmd = wb_dat_i[`CTRL_RESET_BIT];
                  dst_en_d = wb_dat_i[`CTRL_DST_EN_BIT];
                  dst_mode_d = tariff_pkg::dst_mode_t'(wb_dat_i[`CTRL_DST_MODE_BIT]);
                  dem_type_d = tariff_pkg::demand_type_t'(wb_dat_i[`CTRL_DEMAND_TYPE_BIT]);
               end
            end
            `OFF_CAL_SEL: sel_d = CW'(be_merge(32'(sel_q), wb_dat_i, wb_sel_i));
            `OFF_CAL_YEAR: begin
               if (int'(sel_q) < NUM_CAL) begin
                  if (wb_sel_i[0]) begin
                     year_d[sel_q] = wb_dat_i[6:0];
                  end
                  if (wb_sel_i[1]) begin
                     valid_d[sel_q] = wb_dat_i[`CAL_VALID_BIT];
                  end
               end
            end
            `OFF_DST_START: dst_start_d = 9'(be_merge(32'(dst_start_q), wb_dat_i, wb_sel_i));
            `OFF_DST_END: dst_end_d = 9'(be_merge(32'(dst_end_q), wb_dat_i, wb_sel_i));
            `OFF_DEMAND_INT: dem_int_d = 8'(be_merge(32'(dem_int_q), wb_dat_i, wb_sel_i));
            default: begin
               for (int s = 0; s < `SEASON_NUM; s++) begin
                  if ((wb_adr_i == `OFF_SEASON_BASE + 16'(s * 4)) && (int'(sel_q) < NUM_CAL)) begin
                     season_d[sel_q][s] =
                        9'(be_merge(32'(season_q[sel_q][s]), wb_dat_i, wb_sel_i));
                  end
               end
               for (int m = 0; m < `MONTH_NUM; m++) begin
                  if ((wb_adr_i == `OFF_BILL_BASE + 16'(m * 4)) && (int'(sel_q) < NUM_CAL)) begin
                     bill_d[sel_q][m] = 5'(be_merge(32'(bill_q[sel_q][m]), wb_dat_i, wb_sel_i));
                  end
               end
            end
         endcase
      end

      // date events from the time-of-day counter
      new_day = seen_q && (tod_i.doy != prev_q.doy);
      new_year = seen_q && (tod_i.year != prev_q.year);
      new_min = seen_q && (tod_i.minute != prev_q.minute);

      // at the year crossing the next stored calendar takes over
      act_chk = new_year ? cal_idx : act_q;
      if (new_year && run_q) begin
         // no calendar for the new year stops accumulation
         // so the last energy taken is that of 12/31 23:59
         run_d = cal_hit;
         act_d = cal_idx;
      end

      // a start or billing date also ends the period before it
      // season closes as its successor's start day begins
      season_end = 1'b0;
      for (int s = 0; s < `SEASON_NUM; s++) begin
         if (season_q[act_chk][s] == tod_i.doy) begin
            season_end = 1'b1;
         end
      end
      // month closes as its billing day begins
      month_end = (tod_i.month >= 4'h1) && (tod_i.month <= 4'(`MONTH_NUM)) &&
                  (bill_q[act_chk][tod_i.month - 4'h1] != `BILL_NONE) &&
                  (bill_q[act_chk][tod_i.month - 4'h1] == tod_i.mday);
      season_end = season_end && new_day && run_d;
      month_end = month_end && new_day && run_d;
      close_any = season_end || month_end;

      // a replaced calendar is picked up at period end or by the reset command
      if (close_any && cal_hit) begin
         act_d = cal_idx;
      end

      // roll current into prior and clear current
      // prior totals are written only here
      for (int r = 0; r < `RATE_NUM; r++) begin
         if (season_end) begin
            acc_d[tariff_pkg::GRP_PRIOR_SEASON][r] = acc_q[tariff_pkg::GRP_CUR_SEASON][r];
            acc_d[tariff_pkg::GRP_CUR_SEASON][r] = '0;
         end
         if (month_end) begin
            acc_d[tariff_pkg::GRP_PRIOR_MONTH][r] = acc_q[tariff_pkg::GRP_CUR_MONTH][r];
            acc_d[tariff_pkg::GRP_CUR_MONTH][r] = '0;
         end
         if (reset_cmd) begin
            acc_d[tariff_pkg::GRP_CUR_SEASON][r] = '0;
            acc_d[tariff_pkg::GRP_CUR_MONTH][r] = '0;
         end
      end
      // restart from today with the newest calendar
      if (reset_cmd) begin
         run_d = cal_hit;
         act_d = cal_idx;
      end

      // energy keeps flowing while calendars are written
      // season and month totals are kept apart
      accept = energy_valid_i && run_d;
      if (accept) begin
         acc_d[tariff_pkg::GRP_CUR_SEASON][rate_sel] =
            acc_d[tariff_pkg::GRP_CUR_SEASON][rate_sel] + ACC_W'(energy_amount_i);
         acc_d[tariff_pkg::GRP_CUR_MONTH][rate_sel] =
            acc_d[tariff_pkg::GRP_CUR_MONTH][rate_sel] + ACC_W'(energy_amount_i);
         dem_acc_d = dem_acc_q + ACC_W'(energy_amount_i);
      end

      // demand by block or rolling window of subintervals
      if (new_min) begin
         if ((dem_cnt_q + 8'h01) >= dem_int_q) begin
            dem_cnt_d = 8'h00;
            dem_acc_d = '0;
            sub_d[0] = dem_acc_q;
            for (int k = 1; k < `ROLL_SUBS; k++) begin
               sub_d[k] = sub_q[k-1];
            end
            for (int k = 0; k < `ROLL_SUBS; k++) begin
               sub_sum = sub_sum + sub_d[k];
            end
            demand_d = (dem_type_q == tariff_pkg::DEMAND_ROLLING) ? sub_sum : dem_acc_q;
         end else begin
            dem_cnt_d = dem_cnt_q + 8'h01;
         end
      end

      // automatic summer time, second march sunday to first november sunday
      sun_ofs = tod_i.mday - 5'(tod_i.wday);
      dst_d = 1'b0;
      if (dst_en_q) begin
         if (dst_mode_q == tariff_pkg::DST_USER) begin
            dst_d = (tod_i.doy >= dst_start_q) && (tod_i.doy < dst_end_q);
         end else if ((tod_i.month > `DST_MARCH) && (tod_i.month < `DST_NOV)) begin
            dst_d = 1'b1;
         end else if (tod_i.month == `DST_MARCH) begin
            dst_d = (tod_i.mday > 5'(tod_i.wday)) && (sun_ofs >= `DST_SECOND_SUN);
         end else if (tod_i.month == `DST_NOV) begin
            dst_d = tod_i.mday <= 5'(tod_i.wday);
         end
      end

      // every total stays readable at all times
      rd = 32'h0000_0000;
      if (wb_adr_i[15:8] == `REGION_ACC) begin
         rd = 32'(acc_q[wb_adr_i[6:5]][wb_adr_i[4:2]]);
      end else if (day_hit) begin
         rd = 32'(day_mem[day_addr(sel_q, 9'(day_idx + 1))]);
      end else if (slot_hit) begin
         rd = 32'(slot_mem[int'(sel_q) * `SCHED_NUM * `SLOT_NUM + slot_idx]);
      end else begin
         unique case (wb_adr_i)
            `OFF_CTRL: begin
               rd[`CTRL_DST_EN_BIT] = dst_en_q;
               rd[`CTRL_DST_MODE_BIT] = dst_mode_q;
               rd[`CTRL_DEMAND_TYPE_BIT] = dem_type_q;
            end
            `OFF_CAL_SEL: rd = 32'(sel_q);
            `OFF_CAL_YEAR: begin
               rd[6:0] = year_q[sel_q];
               rd[`CAL_VALID_BIT] = valid_q[sel_q];
            end
            `OFF_STATUS: begin
               rd[CW-1:0] = act_q;
               rd[`STAT_RUN_BIT] = run_q;
               rd[`STAT_DST_BIT] = dst_q;
               rd[`STAT_SLOT_LSB +: 7] = slot_q;
            end
            `OFF_DST_START: rd = 32'(dst_start_q);
            `OFF_DST_END: rd = 32'(dst_end_q);
            `OFF_DEMAND_INT: rd = 32'(dem_int_q);
            `OFF_DEMAND: rd = 32'(demand_q);
            default: begin
               for (int s = 0; s < `SEASON_NUM; s++) begin
                  if (wb_adr_i == `OFF_SEASON_BASE + 16'(s * 4)) begin
                     rd = 32'(season_q[sel_q][s]);
                  end
               end
               for (int m = 0; m < `MONTH_NUM; m++) begin
                  if (wb_adr_i == `OFF_BILL_BASE + 16'(m * 4)) begin
                     rd = 32'(bill_q[sel_q][m]);
                  end
               end
            end
         endcase
      end

      ack_d = req && !ack_q;
      dat_d = (req && !ack_q) ? rd : dat_q;
   end

   // ---------------------------------------------------------------
   // calendar memories, no reset so they map onto ram
   // ---------------------------------------------------------------
   // written through the bus at any time
   always_ff @(posedge clk) begin
      if (wr && day_hit) begin
         day_mem[day_addr(sel_q, 9'(day_idx + 1))] <= wb_dat_i[3:0];
      end
      if (wr && slot_hit) begin
         slot_mem[int'(sel_q) * `SCHED_NUM * `SLOT_NUM + slot_idx] <= wb_dat_i[2:0];
      end
   end

   // ---------------------------------------------------------------
   // state registers
   // ---------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         for (int c = 0; c < NUM_CAL; c++) begin
            year_q[c] <= 7'h00;
            valid_q[c] <= 1'b0;
            for (int s = 0; s < `SEASON_NUM; s++) begin
               season_q[c][s] <= `SEASON_NONE;
            end
            for (int m = 0; m < `MONTH_NUM; m++) begin
               bill_q[c][m] <= `BILL_NONE;
            end
         end
         for (int g = 0; g < `GROUP_NUM; g++) begin
            for (int r = 0; r < `RATE_NUM; r++) begin
               acc_q[g][r] <= '0;
            end
         end
         for (int k = 0; k < `ROLL_SUBS; k++) begin
            sub_q[k] <= '0;
         end
         ack_q <= 1'b0;
         dat_q <= 32'h0000_0000;
         sel_q <= '0;
         act_q <= '0;
         run_q <= 1'b0;
         dst_en_q <= 1'b0;
         dst_mode_q <= tariff_pkg::DST_AUTO;
         dem_type_q <= tariff_pkg::DEMAND_BLOCK;
         dst_start_q <= `DST_START_RST;
         dst_end_q <= `DST_END_RST;
         dst_q <= 1'b0;
         dem_int_q <= `DEMAND_INT_RST;
         dem_cnt_q <= 8'h00;
         dem_acc_q <= '0;
         demand_q <= '0;
         slot_q <= 7'h00;
         seen_q <= 1'b0;
         prev_q <= '0;
      end else begin
         year_q <= year_d;
         valid_q <= valid_d;
         season_q <= season_d;
         bill_q <= bill_d;
         acc_q <= acc_d;
         sub_q <= sub_d;
         ack_q <= ack_d;
         dat_q <= dat_d;
         sel_q <= sel_d;
         act_q <= act_d;
         run_q <= run_d;
         dst_en_q <= dst_en_d;
         dst_mode_q <= dst_mode_d;
         dem_type_q <= dem_type_d;
         dst_start_q <= dst_start_d;
         dst_end_q <= dst_end_d;
         dst_q <= dst_d;
         dem_int_q <= dem_int_d;
         dem_cnt_q <= dem_cnt_d;
         dem_acc_q <= dem_acc_d;
         demand_q <= demand_d;
         slot_q <= slot_d;
         seen_q <= seen_d;
         prev_q <= prev_d;
      end
   end

   assign wb_ack_o = ack_q;
   assign wb_dat_o = dat_q;
   assign running_o = run_q;
   assign automatic_summer_time_o = dst_q;

endmodule

// file: rtl/tariff_cfg.svh
// address map, field positions, reset values and counts of the tariff period accumulator
`ifndef TARIFF_CFG_SVH
`define TARIFF_CFG_SVH

// ---------------------------------------------------------------
// storage counts
// ---------------------------------------------------------------
`define CAL_NUM 20
`define SCHED_NUM 16
`define RATE_NUM 8
`define SEASON_NUM 4
`define MONTH_NUM 12
`define GROUP_NUM 4
`define DAY_NUM 366
`define SLOT_NUM 96
`define SLOT_MIN 11'h00F
`define DAY_MIN 11'h5A0
`define DST_SHIFT_MIN 11'h03C
`define ROLL_SUBS 4

// ---------------------------------------------------------------
// register offsets (byte addresses)
// ---------------------------------------------------------------
`define OFF_CTRL 16'h0000
`define OFF_CAL_SEL 16'h0004
`define OFF_CAL_YEAR 16'h0008
`define OFF_STATUS 16'h000C
`define OFF_DST_START 16'h0010
`define OFF_DST_END 16'h0014
`define OFF_DEMAND_INT 16'h0018
`define OFF_DEMAND 16'h001C
`define OFF_SEASON_BASE 16'h0020
`define OFF_BILL_BASE 16'h0040
`define REGION_ACC 8'h01
`define REGION_DAY 4'h1
`define REGION_SLOT 3'h1

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define CTRL_RESET_BIT 0
`define CTRL_DST_EN_BIT 1
`define CTRL_DST_MODE_BIT 2
`define CTRL_DEMAND_TYPE_BIT 3
`define CAL_VALID_BIT 8
`define STAT_RUN_BIT 8
`define STAT_DST_BIT 9
`define STAT_SLOT_LSB 16

// ---------------------------------------------------------------
// reset values and special codes
// ---------------------------------------------------------------
`define SEASON_NONE 9'h1FF
`define BILL_NONE 5'h00
`define DEMAND_INT_RST 8'h0F
`define DST_START_RST 9'h000
`define DST_END_RST 9'h000
`define DST_MARCH 4'h3
`define DST_NOV 4'hB
`define DST_SECOND_SUN 5'h08

`endif

// file: rtl/tariff_pkg.sv
// types shared by the tariff period accumulator and its bench
package tariff_pkg;

   // time of day and date from the device real-time counter
   typedef struct packed {
      logic [6:0] year;
      logic [3:0] month;
      logic [4:0] mday;
      logic [8:0] doy;
      logic [2:0] wday;
      logic [10:0] minute;
   } tod_t;

   typedef enum logic [0:0] {
      DEMAND_BLOCK = 1'h0,
      DEMAND_ROLLING = 1'h1
   } demand_type_t;

   typedef enum logic [0:0] {
      DST_AUTO = 1'h0,
      DST_USER = 1'h1
   } dst_mode_t;

   typedef enum logic [1:0] {
      GRP_CUR_SEASON = 2'h0,
      GRP_CUR_MONTH = 2'h1,
      GRP_PRIOR_SEASON = 2'h2,
      GRP_PRIOR_MONTH = 2'h3
   } acc_group_t;

endpackage

// file: tb/tariff_properties.sv
// bus and run checks for the tariff period accumulator
`timescale 1ns/1ps
module tariff_properties (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [15:0] wb_adr_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic running_o
);
   // ------
   // checks
   // ------
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   wire logic take = wb_cyc_i && wb_stb_i && !wb_ack_o;
   wire logic rd_st = take && !wb_we_i && wb_adr_i == 16'h000C;
   wire logic wr_ok = wb_ack_o && wb_we_i;
   chk_ack_answer: assert property (take |=> wb_ack_o)
      else $error("ack missing");
   chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack too long");
   chk_ack_cause: assert property ($rose(wb_ack_o) |-> $past(take))
      else $error("ack without request");
   chk_dat_hold: assert property (!$stable(wb_dat_o) |-> $past(take))
      else $error("read data moved");
   chk_unmapped_zero: assert property (take && !wb_we_i && wb_adr_i == 16'h0800
      |=> wb_dat_o == 32'h0) else $error("unmapped read not zero");
   chk_slot_range: assert property (rd_st |=> wb_dat_o[22:16] < 7'h60)
      else $error("slot out of range");
   chk_status_run: assert property (rd_st |=> wb_dat_o[8] == $past(running_o))
      else $error("status run bit wrong");
   chk_run_start: assert property ($rose(running_o) |-> $past(wr_ok) || $past(wr_ok, 2))
      else $error("run started without write");
   cover property (take && wb_we_i);
   cover property ($rose(running_o));
   cover property ($fell(running_o));
endmodule

bind tariff_period_accumulator tariff_properties chk (.clk, .reset_n, .wb_cyc_i,
   .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o, .running_o);

// file: tb/tariff_host.sv
// wishbone master standing in for the host software
`timescale 1ns/1ps
module tariff_host (
   output logic cyc,
   output logic stb,
   output logic we,
   output logic [15:0] adr,
   output logic [3:0] sel,
   output logic [31:0] dat,
   input wire logic clk,
   input wire logic ack,
   input wire logic [31:0] rdat
);
   // ----------
   // bus cycles
   // ----------
   initial {cyc, stb, we, adr, sel, dat} = '0;
   // request stands until the rising edge that samples ack high
   task automatic xfer(input logic w, input logic [15:0] a, input logic [31:0] d,
      output logic [31:0] q);
      @(posedge clk);
      {cyc, stb, we, adr, sel, dat} <= {2'b11, w, a, 4'hF, d};
      @(posedge clk);
      while (ack !== 1'b1) @(posedge clk);
      q = rdat;
      {cyc, stb} <= 2'b00;
   endtask
   task automatic reset_current;
      logic [31:0] q;
      xfer(1'b1, 16'h0000, 32'h1, q);
   endtask
endmodule

// file: tb/tariff_period_accumulator_bench.sv
// self-checking bench for the tariff period accumulator
`timescale 1ns/1ps
module tariff_period_accumulator_bench;
   typedef struct packed {logic [15:0] a; logic [31:0] w; logic [31:0] e;} row_t;
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic ev = 1'b0;
   logic cyc, stb, we, ack, run, sum;
   logic [15:0] adr;
   logic [15:0] amt = 16'h0;
   logic [3:0] sel;
   logic [31:0] wdat, rdat, q;
   tariff_pkg::tod_t tod = {7'h05, 4'h1, 5'h01, 9'h001, 3'h0, 11'h59F};
   int n_mismatch = 0;
   int samples_checked = 0;
   row_t rows [8] = '{{16'h0004, 32'h13, 32'h13}, {16'h0008, 32'h115, 32'h115},
      {16'h0010, 32'h50, 32'h50}, {16'h0014, 32'h60, 32'h60}, {16'h0018, 32'h1E, 32'h1E},
      {16'h002C, 32'h10A, 32'h10A}, {16'h006C, 32'h1F, 32'h1F}, {16'h0800, 32'hF, 32'h0}};
   always #12.5 clk = ~clk;
   tariff_host host (.clk, .cyc, .stb, .we, .adr, .sel, .dat(wdat), .ack, .rdat);
   tariff_period_accumulator dut (.clk, .reset_n, .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
      .wb_ack_o(ack), .tod_i(tod), .energy_valid_i(ev), .energy_amount_i(amt),
      .running_o(run), .automatic_summer_time_o(sum));
   // -----
   // tasks
   // -----
   task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
      samples_checked++;
      if (g !== e) begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic wr(input logic [15:0] a, input logic [31:0] d);
      host.xfer(1'b1, a, d, q);
   endtask
   task automatic rd(input logic [15:0] a, input logic [31:0] e);
      host.xfer(1'b0, a, 32'h0, q);
      cmp($sformatf("reg %h", a), e, q);
   endtask
   task automatic pulse(input logic [15:0] a);
      @(posedge clk);
      {ev, amt} <= {1'b1, a};
      @(posedge clk);
      ev <= 1'b0;
   endtask
   task automatic conclude;
      if (n_mismatch == 0 && samples_checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   initial begin
      repeat (5000) @(posedge clk);
      n_mismatch++;
      conclude();
   end
   initial begin
      repeat (3) @(posedge clk);
      reset_n <= 1'b1;
      rd(16'h0020, 32'h1FF);
      rd(16'h0018, 32'hF);
      for (int i = 0; i < 8; i++) begin
         wr(rows[i].a, rows[i].w);
         rd(rows[i].a, rows[i].e);
      end
      // calendar 0: last slot of day picks rate 2, month and season close on day 2
      wr(16'h0004, 32'h0);
      wr(16'h0008, 32'h105);
      wr(16'h1000, 32'h0);
      wr(16'h1004, 32'h0);
      wr(16'h217C, 32'h2);
      wr(16'h0040, 32'h2);
      wr(16'h0024, 32'h2);
      host.reset_current();
      rd(16'h000C, 32'h005F0100);
      cmp("running", 32'h1, {31'h0, run});
      pulse(16'h0007);
      rd(16'h0108, 32'h7);
      rd(16'h0128, 32'h7);
      @(posedge clk);
      {tod.doy, tod.mday} <= {9'h002, 5'h02};
      rd(16'h0168, 32'h7);
      rd(16'h0128, 32'h0);
      rd(16'h0148, 32'h7);
      rd(16'h0108, 32'h0);
      pulse(16'h0003);
      rd(16'h0128, 32'h3);
      host.reset_current();
      rd(16'h0128, 32'h0);
      rd(16'h0168, 32'h7);
      // demand: block sum, then rolling sum of the last subintervals
      wr(16'h0018, 32'h1);
      pulse(16'h0004);
      @(posedge clk);
      tod.minute <= 11'h59E;
      rd(16'h001C, 32'hE);
      wr(16'h0000, 32'h8);
      pulse(16'h0002);
      @(posedge clk);
      tod.minute <= 11'h59D;
      rd(16'h001C, 32'h10);
      // summer time in july moves the slot by an hour
      @(posedge clk);
      tod.month <= 4'h7;
      wr(16'h0000, 32'h2);
      repeat (2) @(posedge clk);
      rd(16'h000C, 32'h00030300);
      cmp("summer", 32'h1, {31'h0, sum});
      wr(16'h0000, 32'h6);
      repeat (2) @(posedge clk);
      cmp("summer", 32'h0, {31'h0, sum});
      // a second calendar for the same year waits for the reset command
      wr(16'h0004, 32'h1);
      wr(16'h0008, 32'h105);
      rd(16'h000C, 32'h005F0100);
      host.reset_current();
      rd(16'h000C, 32'h005F0101);
      @(posedge clk);
      tod.year <= 7'h06;
      pulse(16'h0005);
      rd(16'h0128, 32'h0);
      cmp("running", 32'h0, {31'h0, run});
      cmp("summer", 32'h0, {31'h0, sum});
      // reset after the year-end stop brings back the power-up values
      @(posedge clk);
      reset_n <= 1'b0;
      repeat (2) @(posedge clk);
      reset_n <= 1'b1;
      rd(16'h0018, 32'hF);
      rd(16'h0008, 32'h0);
      cmp("running", 32'h0, {31'h0, run});
      conclude();
   end
endmodule
